//--- bench/dtt_trace_analyzer.sv
// Trace port analyzer model: captures trace words and stalls on command.
// Assumes pins are registered on ref_clk and quiet when idle.
`timescale 1ns/1ps
`default_nettype none
module dtt_trace_analyzer (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // Trace port pins
   input  wire logic        trace_sync,
   input  wire logic [2:0]  pipe_status,
   input  wire logic [15:0] trace_packet,
   // Stall control: 0 none, 1 pattern, 2 stuck
   input  wire logic [1:0]  hold_mode,
   output logic             trace_hold
);
   logic [19:0] cap_q[$];
   logic [2:0]  cnt_q;

   // Sample every rising ref_clk edge, i.e. both trace clock edges
   always @(posedge ref_clk) begin
      if (!sys_rst && pipe_status !== 3'h0) begin
         cap_q.push_back({trace_sync, pipe_status, trace_packet});
      end
   end

   // Stall pattern; a real analyzer may stall at any time
   always_ff @(posedge ref_clk) begin
      cnt_q      <= sys_rst ? 3'h0 : cnt_q + 3'h1;
      trace_hold <= (hold_mode == 2'h2) || (hold_mode == 2'h1 && cnt_q[1:0] == 2'h0);
   end
endmodule
`default_nettype wire

//--- bench/test_debug_test_trace_port.sv
// Self-checking bench of the debug, test and trace port.
// Assumes the design package and dtt_trace_analyzer are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_debug_test_trace_port;
   import dtt_pkg::*;
   localparam logic [31:0] ID = 32'h5a5a_0c3e; // Arbitrary value
   logic        ref_clk, sys_rst, clk_en, chip_reset_n, test_logic_reset_n;
   logic        test_mode_sel0, test_mode_sel1, port_select, tap_shift, trc_in_valid;
   logic        chan_tx_empty, chan_rx_full, dbg_uart_rx, uart_tx_bit, uart_rx_avail;
   logic        uart_tx_space, ice_sel, bscan_sel, normal_mode, test_mode_bad, ice_rst_n;
   logic        uart_rx_bit, dbg_uart_tx, irq_tx_empty, irq_rx_full, dma_rx_req, dma_tx_req;
   logic        trc_in_ready, trc_ext_out, trace_hold, trace_clock, trace_sync;
   logic        p_rst, p_en, p_trace_clock, p_crst;
   logic [2:0]  tap_chain, pipe_status;
   logic [3:0]  trc_ext_in;
   logic [5:0]  scan_shift_en, p_in;
   logic [15:0] trace_packet;
   logic [31:0] chip_id, xs_q;
   logic [1:0]  hold_mode;
   logic [19:0] exp_q[$];
   logic [19:0] got;
   dtt_trace_t  trc_in;
   int          mismatches, compares, n_left, guard;

   dtt_debug_port #(.CHIP_ID(ID)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .clk_en(clk_en), .chip_reset_n(chip_reset_n), .test_logic_reset_n(test_logic_reset_n),
      .test_mode_sel0(test_mode_sel0), .test_mode_sel1(test_mode_sel1),
      .port_select(port_select), .tap_shift(tap_shift), .tap_chain(tap_chain),
      .ice_sel(ice_sel), .bscan_sel(bscan_sel), .normal_mode(normal_mode),
      .test_mode_bad(test_mode_bad), .ice_rst_n(ice_rst_n), .scan_shift_en(scan_shift_en),
      .chan_tx_empty(chan_tx_empty), .chan_rx_full(chan_rx_full), .dbg_uart_rx(dbg_uart_rx),
      .uart_tx_bit(uart_tx_bit), .uart_rx_avail(uart_rx_avail),
      .uart_tx_space(uart_tx_space), .uart_rx_bit(uart_rx_bit), .dbg_uart_tx(dbg_uart_tx),
      .irq_tx_empty(irq_tx_empty), .irq_rx_full(irq_rx_full), .dma_rx_req(dma_rx_req),
      .dma_tx_req(dma_tx_req), .chip_id(chip_id), .trc_in(trc_in),
      .trc_in_valid(trc_in_valid), .trc_in_ready(trc_in_ready), .trc_ext_in(trc_ext_in),
      .trc_ext_out(trc_ext_out), .trace_hold(trace_hold), .trace_clock(trace_clock),
      .trace_sync(trace_sync), .pipe_status(pipe_status), .trace_packet(trace_packet));

   dtt_trace_analyzer ana_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .trace_sync(trace_sync),
      .pipe_status(pipe_status), .trace_packet(trace_packet), .hold_mode(hold_mode),
      .trace_hold(trace_hold));

   // --------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------
   // Fixed-seed xorshift keeps every run identical
   function automatic logic [31:0] xs();
      xs_q = xs_q ^ (xs_q << 13);
      xs_q = xs_q ^ (xs_q >> 17);
      xs_q = xs_q ^ (xs_q << 5);
      return xs_q;
   endfunction

   // Pin image of one accepted word: unused byte lanes read zero
   function automatic logic [19:0] exp_word(input dtt_trace_t w);
      logic [15:0] pk;
      pk = (w.npk == 2'h0) ? 16'h0 : (w.npk == 2'h1) ? {8'h0, w.pkts[7:0]} : w.pkts;
      return {w.sync, w.pipe, pk};
   endfunction

   task automatic check(input logic ok, input string msg);
      compares++;
      if (!ok) begin
         mismatches++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask

   task automatic test_done();
      if (mismatches == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // One cycle: record acceptance, then drive new random pins and stream word
   task automatic tick();
      logic [31:0] r;
      logic        acc;
      @(posedge ref_clk);
      acc = clk_en && trc_in_valid && trc_in_ready === 1'b1;
      if (acc) exp_q.push_back(exp_word(trc_in));
      #1;
      r = xs();
      {trc_ext_in, uart_tx_space, uart_rx_avail, uart_tx_bit, dbg_uart_rx, chan_rx_full,
       chan_tx_empty} = r[9:0];
      if (acc || !trc_in_valid) begin
         trc_in_valid = n_left > 0 && r[10];
         if (trc_in_valid) begin
            n_left--;
            trc_in = {r[11], (r[14:12] == 3'h0) ? 3'h1 : r[14:12], r[16:15], 16'(xs())};
         end
      end
   endtask

   // Clock
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // Hang guard, sized well above the planned traffic
   initial begin
      #(40 * 20000);
      mismatches++;
      test_done();
   end

   // Per-cycle copies, trace clock, idle trace port and constant outputs
   always @(negedge ref_clk) begin
      if (!sys_rst && !p_rst) begin
         check(p_en ? trace_clock !== p_trace_clock : trace_clock === p_trace_clock, "trace clock");
         check(!p_en || {irq_rx_full, irq_tx_empty} === p_in[1:0], "channel irq");
         check(!p_en || {dma_tx_req, dma_rx_req, dbg_uart_tx, uart_rx_bit} === p_in[5:2],
               "uart copy");
         check(trc_ext_out === 1'b0 && chip_id === ID, "ext out or id");
         check(p_crst || {trace_sync, pipe_status, trace_packet} === 20'h0, "trace idle");
      end
      p_rst  = sys_rst;
      p_en   = clk_en;
      p_trace_clock = trace_clock;
      p_crst = chip_reset_n;
      p_in   = {uart_tx_space, uart_rx_avail, uart_tx_bit, dbg_uart_rx, chan_rx_full,
                chan_tx_empty};
   end

   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      xs_q = 32'd97628;
      {sys_rst, clk_en, chip_reset_n, test_logic_reset_n} = 4'hf;
      {test_mode_sel0, test_mode_sel1, port_select, tap_shift, trc_in_valid} = 5'h0;
      {chan_tx_empty, chan_rx_full, dbg_uart_rx, uart_tx_bit, uart_rx_avail} = 5'h0;
      {uart_tx_space, tap_chain, trc_ext_in, hold_mode, trc_in} = '0;
      {p_rst, mismatches, compares, n_left} = '1;
      {mismatches, compares, n_left} = '0;
      repeat (5) tick();
      check(chip_id === ID && ice_sel === 1'b1 && bscan_sel === 1'b0, "reset values");
      sys_rst = 1'b0;
      // Test mode pin combinations
      for (int i = 0; i < 4; i++) begin
         {test_mode_sel1, test_mode_sel0} = 2'(i);
         repeat (2) tick();
         check(normal_mode === (i == 0) && test_mode_bad === (i != 0), "test mode");
      end
      {test_mode_sel1, test_mode_sel0} = 2'h0;
      // Boundary scan chosen under both resets
      {chip_reset_n, test_logic_reset_n, port_select} = 3'b001;
      repeat (4) tick();
      check(bscan_sel === 1'b1 && ice_sel === 1'b0 && ice_rst_n === 1'b0, "bscan");
      {chip_reset_n, test_logic_reset_n, port_select, tap_shift} = 4'b1101;
      repeat (4) tick();
      check(bscan_sel === 1'b1 && scan_shift_en === 6'h0, "no switch");
      chip_reset_n = 1'b0;
      repeat (4) tick();
      check(bscan_sel === 1'b1 && ice_rst_n === 1'b1, "chip reset alone");
      test_logic_reset_n = 1'b0;
      repeat (4) tick();
      check(ice_sel === 1'b1 && bscan_sel === 1'b0, "emulator");
      {chip_reset_n, test_logic_reset_n} = 2'b11;
      // Each scan chain in emulator mode
      for (int c = 0; c < 6; c++) begin
         tap_chain = 3'(c);
         repeat (2) tick();
         check(scan_shift_en === 6'h1 << c, "scan chain");
      end
      tap_shift = 1'b0;
      repeat (2) tick();
      check(scan_shift_en === 6'h0, "scan idle");
      // Freeze
      clk_en = 1'b0;
      repeat (3) tick();
      clk_en = 1'b1;
      // Fill the buffer against a stuck stall
      hold_mode = 2'h2;
      n_left = 4;
      repeat (12) tick();
      check(exp_q.size() == 2 && trc_in_ready === 1'b0, "buffer full");
      // Random stream with a stalling analyzer
      hold_mode = 2'h1;
      n_left = 300;
      guard = 0;
      while ((n_left > 0 || trc_in_valid) && guard < 5000) begin
         tick();
         guard++;
      end
      hold_mode = 2'h0;
      repeat (8) tick();
      check(ana_u.cap_q.size() == exp_q.size(), "word count");
      while (exp_q.size() > 0 && ana_u.cap_q.size() > 0) begin
         got = ana_u.cap_q.pop_front();
         check(got === exp_q.pop_front(), "trace word");
      end
      test_done();
   end
endmodule
`default_nettype wire

//--- design/dtt_cfg.svh
// Constants of the debug, test and trace port block.
// Assumes it is included by bare name from the package and the top module.
`ifndef DTT_CFG_SVH
`define DTT_CFG_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define DTT_REF_CLK_HZ      25000000
`define DTT_TRACE_DIV       2

// ----------------------------------------------------------------
// Trace word layout
// ----------------------------------------------------------------
`define DTT_PS_W            3
`define DTT_PK_W            8
`define DTT_PK_NUM          2
`define DTT_NPK_W           2
`define DTT_PS_IDLE         3'h0

// ----------------------------------------------------------------
// Trace unit resources and buffer
// ----------------------------------------------------------------
`define DTT_ADDR_CMP_PAIRS  4
`define DTT_DATA_CMP        2
`define DTT_MMAP_INPUTS     8
`define DTT_COUNTERS        2
`define DTT_SEQUENCERS      1
`define DTT_TRACE_FIFO_B    18
`define DTT_BUF_DEPTH       2

// ----------------------------------------------------------------
// Scan chains and reset values
// ----------------------------------------------------------------
`define DTT_SCAN_CHAINS     6
`define DTT_CHAIN_W         3
`define DTT_MODE_RST        1'b0
`define DTT_CHIP_ID_DEF     32'h0000_0001

`endif

//--- design/dtt_debug_port.sv
// Debug and test port: JTAG routing, test mode check, debug channel
// interrupts, chip id and the half-rate trace port.
// Assumes one 25 MHz clock; all pin inputs are synchronous to ref_clk.
`include "dtt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module dtt_debug_port #(
   parameter int          ADDR_CMP_PAIRS = `DTT_ADDR_CMP_PAIRS,
   parameter int          DATA_CMP       = `DTT_DATA_CMP,
   parameter int          MMAP_INPUTS    = `DTT_MMAP_INPUTS,
   parameter int          COUNTERS       = `DTT_COUNTERS,
   parameter int          TRACE_FIFO_B   = `DTT_TRACE_FIFO_B,
   parameter logic [31:0] CHIP_ID        = `DTT_CHIP_ID_DEF  // Arbitrary value
) (
   // Clock, reset, enable
   input  wire logic                              ref_clk,
   input  wire logic                              sys_rst,
   input  wire logic                              clk_en,
   // Reset and test pins
   input  wire logic                              chip_reset_n,
   input  wire logic                              test_logic_reset_n,
   input  wire logic                              test_mode_sel0,
   input  wire logic                              test_mode_sel1,
   input  wire logic                              port_select,
   // JTAG state machine side
   input  wire logic                              tap_shift,
   input  wire logic [`DTT_CHAIN_W-1:0]           tap_chain,
   output logic                                   ice_sel,
   output logic                                   bscan_sel,
   output logic                                   normal_mode,
   output logic                                   test_mode_bad,
   output logic                                   ice_rst_n,
   output logic [`DTT_SCAN_CHAINS-1:0]            scan_shift_en,
   // Debug channel and UART
   input  wire logic                              chan_tx_empty,
   input  wire logic                              chan_rx_full,
   input  wire logic                              dbg_uart_rx,
   input  wire logic                              uart_tx_bit,
   input  wire logic                              uart_rx_avail,
   input  wire logic                              uart_tx_space,
   output logic                                   uart_rx_bit,
   output logic                                   dbg_uart_tx,
   output logic                                   irq_tx_empty,
   output logic                                   irq_rx_full,
   output logic                                   dma_rx_req,
   output logic                                   dma_tx_req,
   output logic [31:0]                            chip_id,
   // Trace source from the trace unit
   input  wire dtt_pkg::dtt_trace_t               trc_in,
   input  wire logic                              trc_in_valid,
   output logic                                   trc_in_ready,
   input  wire logic [3:0]                        trc_ext_in,
   output logic                                   trc_ext_out,
   // Trace port pins
   input  wire logic                              trace_hold,
   output logic                                   trace_clock,
   output logic                                   trace_sync,
   output logic [`DTT_PS_W-1:0]                   pipe_status,
   output logic [`DTT_PK_NUM*`DTT_PK_W-1:0]       trace_packet
);
   import dtt_pkg::*;

   // ----------------------------------------------------------------
   // Resource checks
   // ----------------------------------------------------------------
   // Comparators, decoders and counters live in the trace unit; their
   // counts are fixed here so a mismatched build is flagged on the first clock.
   a_res_counts: assert property (@(posedge ref_clk)
      ADDR_CMP_PAIRS == `DTT_ADDR_CMP_PAIRS && DATA_CMP == `DTT_DATA_CMP &&
      MMAP_INPUTS == `DTT_MMAP_INPUTS && COUNTERS == `DTT_COUNTERS &&
      TRACE_FIFO_B >= `DTT_PK_NUM)
      else $error("trace resource counts differ");

   // ----------------------------------------------------------------
   // Mode selection
   // ----------------------------------------------------------------
   dtt_mode_t mode_q;
   logic      both_rst;

   assign both_rst = !chip_reset_n && !test_logic_reset_n;

   // Port select is only taken while both resets are held, so a change
   // of the pin on the fly never disturbs a running session.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         mode_q <= DTT_MODE_ICE;
      end else if (clk_en && both_rst) begin
         mode_q <= port_select ? DTT_MODE_BSCAN : DTT_MODE_ICE;
      end
   end

   // Routing and test mode outputs
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ice_sel       <= 1'b1;
         bscan_sel     <= 1'b0;
         normal_mode   <= 1'b0;
         test_mode_bad <= 1'b0;
         ice_rst_n     <= 1'b0;
      end else if (clk_en) begin
         ice_sel       <= (mode_q == DTT_MODE_ICE);
         bscan_sel     <= (mode_q == DTT_MODE_BSCAN);
         normal_mode   <= !test_mode_sel0 && !test_mode_sel1;
         test_mode_bad <= test_mode_sel0 || test_mode_sel1;
         ice_rst_n     <= test_logic_reset_n;  // Emulator survives chip reset
      end
   end

   // ----------------------------------------------------------------
   // Scan chain selection
   // ----------------------------------------------------------------
   // Shifting runs only in emulator mode, so the core pipeline and the
   // register dump never see the external data bus.
   for (genvar c = 0; c < `DTT_SCAN_CHAINS; c++) begin : g_chain
      always_ff @(posedge ref_clk) begin
         if (sys_rst) begin
            scan_shift_en[c] <= 1'b0;
         end else if (clk_en) begin
            scan_shift_en[c] <= tap_shift && (mode_q == DTT_MODE_ICE) &&
                                (tap_chain == `DTT_CHAIN_W'(c));
         end
      end
   end

   // ----------------------------------------------------------------
   // Debug channel, UART and chip id
   // ----------------------------------------------------------------
   // Level requests; the interrupt controller masks and clears them.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         irq_tx_empty <= 1'b0;
         irq_rx_full  <= 1'b0;
      end else if (clk_en) begin
         irq_tx_empty <= chan_tx_empty;
         irq_rx_full  <= chan_rx_full;
      end
   end

   // Two pins and two DMA requests; tx idles high like any UART line
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         dbg_uart_tx <= 1'b1;
         uart_rx_bit <= 1'b1;
         dma_rx_req  <= 1'b0;
         dma_tx_req  <= 1'b0;
      end else if (clk_en) begin
         dbg_uart_tx <= uart_tx_bit;
         uart_rx_bit <= dbg_uart_rx;
         dma_rx_req  <= uart_rx_avail;
         dma_tx_req  <= uart_tx_space;
      end
   end

   // Fixed identification; writes do not exist on this path
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         chip_id <= CHIP_ID;
      end
   end

   // Unused trace resources: inputs ignored, output kept low
   always_ff @(posedge ref_clk) begin
      if (sys_rst || clk_en) begin
         trc_ext_out <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Two-entry trace buffer
   // ----------------------------------------------------------------
   // Absorbs one stall of the capture side without losing a word.
   dtt_trace_t buf_q [`DTT_BUF_DEPTH];
   logic       wr_ptr_q;
   logic       rd_ptr_q;
   logic [1:0] cnt_q;
   logic       push;
   logic       pop;

   assign push = clk_en && trc_in_valid && trc_in_ready;
   assign pop  = clk_en && (cnt_q != 2'h0) && !trace_hold && chip_reset_n;

   // Ready is registered so it comes straight from a flip-flop
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cnt_q        <= 2'h0;
         wr_ptr_q     <= 1'b0;
         rd_ptr_q     <= 1'b0;
         trc_in_ready <= 1'b0;
      end else if (clk_en) begin
         cnt_q        <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
         wr_ptr_q     <= wr_ptr_q ^ push;
         rd_ptr_q     <= rd_ptr_q ^ pop;
         trc_in_ready <= (2'(cnt_q + {1'b0, push} - {1'b0, pop}) < 2'h2);
      end
   end

   // Storage holds no reset; occupancy guards every read
   always_ff @(posedge ref_clk) begin
      if (push) begin
         buf_q[wr_ptr_q] <= trc_in;
      end
   end

   // ----------------------------------------------------------------
   // Trace port
   // ----------------------------------------------------------------
   // Divide by two: every output below changes once per ref_clk, that is
   // on each edge of the trace clock, never faster than half rate.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         trace_clock <= 1'b0;
      end else if (clk_en) begin
         trace_clock <= !trace_clock;
      end
   end

   // One word per half trace cycle; idle when empty, held or in reset
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         trace_sync   <= 1'b0;
         pipe_status  <= `DTT_PS_IDLE;
         trace_packet <= '0;
      end else if (clk_en) begin
         if (pop) begin
            trace_sync   <= buf_q[rd_ptr_q].sync;
            pipe_status  <= buf_q[rd_ptr_q].pipe;
            unique case (buf_q[rd_ptr_q].npk)
               2'h0:    trace_packet <= '0;
               2'h1:    trace_packet <= {{`DTT_PK_W{1'b0}},
                                         buf_q[rd_ptr_q].pkts[`DTT_PK_W-1:0]};
               default: trace_packet <= buf_q[rd_ptr_q].pkts;
            endcase
         end else begin
            trace_sync   <= 1'b0;
            pipe_status  <= `DTT_PS_IDLE;
            trace_packet <= '0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_mode_only_reset: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !$past(both_rst) |-> $stable(mode_q))
      else $error("mode changed outside reset");

   a_ice_route: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && both_rst && !port_select ##1 clk_en |=> ice_sel && !bscan_sel)
      else $error("emulator not routed");

   a_bscan_route: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && both_rst && port_select ##1 clk_en |=> bscan_sel && !ice_sel)
      else $error("boundary scan not enabled");

   a_clk_half_rate: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en |=> trace_clock != $past(trace_clock))
      else $error("trace clock not divided by two");

   a_quiet_reset: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && !chip_reset_n |=> !trace_sync && pipe_status == `DTT_PS_IDLE)
      else $error("trace not quiet in chip reset");

   a_no_payload: assert property (@(posedge ref_clk) disable iff (sys_rst)
      pop && buf_q[rd_ptr_q].npk == 2'h0 |=> trace_packet == '0)
      else $error("packet data without payload");

   a_status_match: assert property (@(posedge ref_clk) disable iff (sys_rst)
      pop |=> pipe_status == $past(buf_q[rd_ptr_q].pipe) &&
              trace_sync == $past(buf_q[rd_ptr_q].sync))
      else $error("status does not match word");

   a_buf_full_stall: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cnt_q == 2'h2 |-> !trc_in_ready)
      else $error("ready while buffer full");

   a_irq_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && chan_rx_full |=> irq_rx_full)
      else $error("receive interrupt missed");

   a_chain_single: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $onehot0(scan_shift_en) && (!bscan_sel || scan_shift_en == '0))
      else $error("bad scan chain select");

   a_ext_out_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ##1 !trc_ext_out)
      else $error("external output active");

   a_tx_irq_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && chan_tx_empty |=> irq_tx_empty)
      else $error("transmit interrupt missed");

   a_one_byte_lane: assert property (@(posedge ref_clk) disable iff (sys_rst)
      pop && buf_q[rd_ptr_q].npk == 2'h1 |=> trace_packet[2*`DTT_PK_W-1:`DTT_PK_W] == '0)
      else $error("upper packet lane not empty");

   a_two_byte_lane: assert property (@(posedge ref_clk) disable iff (sys_rst)
      pop && buf_q[rd_ptr_q].npk[1] |=> trace_packet == $past(buf_q[rd_ptr_q].pkts))
      else $error("two packets not carried");

   a_shift_ice_only: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && (!tap_shift || mode_q != DTT_MODE_ICE) |=> scan_shift_en == '0)
      else $error("scan shift outside emulator");

   a_test_mode_pins: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en |=> test_mode_bad == $past(test_mode_sel0 || test_mode_sel1) &&
                 normal_mode != test_mode_bad)
      else $error("test mode flags wrong");

   a_id_fixed: assert property (@(posedge ref_clk) disable iff (sys_rst)
      chip_id == CHIP_ID)
      else $error("chip id changed");

   a_ice_reset_sep: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en |=> ice_rst_n == $past(test_logic_reset_n))
      else $error("emulator reset not separate");

   c_two_packets: cover property (@(posedge ref_clk) disable iff (sys_rst)
      pop && buf_q[rd_ptr_q].npk == 2'h2);
   c_buffer_full: cover property (@(posedge ref_clk) disable iff (sys_rst)
      cnt_q == 2'h2 ##1 trace_hold);
   c_mode_swap: cover property (@(posedge ref_clk) disable iff (sys_rst)
      ice_sel ##[1:20] bscan_sel);
   c_sync_out: cover property (@(posedge ref_clk) disable iff (sys_rst)
      trace_sync);

endmodule

`default_nettype wire

//--- design/dtt_pkg.sv
// Types of the debug, test and trace port block.
// Assumes dtt_cfg.svh is on the include path.
`include "dtt_cfg.svh"

package dtt_pkg;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   // One half trace cycle: sync, pipeline status, packet count, packets
   typedef struct packed {
      logic                                sync;
      logic [`DTT_PS_W-1:0]                pipe;
      logic [`DTT_NPK_W-1:0]               npk;
      logic [`DTT_PK_NUM*`DTT_PK_W-1:0]    pkts;
   } dtt_trace_t;

   // Port routing selected at reset
   typedef enum logic {
      DTT_MODE_ICE,
      DTT_MODE_BSCAN
   } dtt_mode_t;

endpackage
